// >>> tb/ccd_channel_divider_assertions.sv
/*
  port checker for the group two and three channel dividers.
  assumes a bind from the bench top file.
*/
`timescale 1ns/1ps
module ccd_checker
  import ccd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [CCD_AW-1:0] reg_addr,
  input wire logic [CCD_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [CCD_DW-1:0] reg_rdata,
  input wire logic group2_first_output,
  input wire logic group2_second_output,
  input wire logic group2_third_output,
  input wire logic group3_first_output,
  input wire logic group3_second_output,
  input wire logic group3_third_output,
  input wire logic group2_pwrdn,
  input wire logic group3_pwrdn,
  input wire logic group2_duty_fix,
  input wire logic group3_duty_fix
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////
  sequence s_ctl_wr;
    reg_wr && reg_addr == CCD_OFF_DIV3_CTRL ##1 reg_addr == CCD_OFF_DIV3_CTRL;
  endsequence
  property p_rst;
    $fell(reset) |-> !group2_first_output && !group3_first_output && group2_duty_fix
      && group3_duty_fix && !group2_pwrdn && !group3_pwrdn && reg_rdata == 8'h00;
  endproperty
  property p_same2;
    group2_second_output == group2_first_output && group2_third_output == group2_first_output;
  endproperty
  property p_same3;
    group3_second_output == group3_first_output && group3_third_output == group3_first_output;
  endproperty
  property p_pwr;
    group2_pwrdn && $past(group2_pwrdn) |-> !group2_first_output;
  endproperty
  property p_unmap;
    $past(reg_addr) < CCD_OFF_DIV2_COUNTS || $past(reg_addr) > CCD_OFF_CH3_ROUTE
      |-> reg_rdata == 8'h00;
  endproperty
  property p_rtzero;
    $past(reg_addr) == CCD_OFF_CH2_ROUTE |-> reg_rdata[7:3] == 5'h00;
  endproperty
  property p_rdback;
    s_ctl_wr |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  property p_pins;
    reg_wr && reg_addr == CCD_OFF_CH3_ROUTE |=> group3_pwrdn == $past(reg_wdata[2])
      && group3_duty_fix == !$past(reg_wdata[0]);
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_same2: assert property (p_same2) else $error("group2 outputs differ");
  a_same3: assert property (p_same3) else $error("group3 outputs differ");
  a_pwr: assert property (p_pwr) else $error("powered group drives");
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  a_rtzero: assert property (p_rtzero) else $error("unused route bits set");
  a_rdback: assert property (p_rdback) else $error("control readback wrong");
  a_pins: assert property (p_pins) else $error("route pins wrong");
endmodule : ccd_checker

// >>> tb/testbench.sv
/*
  register and output bench for the channel dividers.
  assumes ccd_pkg and the design compiled first.
*/
`timescale 1ns/1ps
module testbench;
  import ccd_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, align_req = 1'b0;
  logic dist_clk_in = 1'b0, osc_clk_in = 1'b0, ext_clk_in = 1'b0;
  logic [1:0] clk_src_sel = 2'h0;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic g2a, g2b, g2c, g3a, g3b, g3c, p2, p3, d2, d3;
  int n_fail = 0, checks_done = 0, cyc = 0, h, l;
  logic [9:0] ra [7] = '{10'h196, 10'h197, 10'h198, 10'h199, 10'h19A, 10'h19B, 10'h000};
  logic [7:0] rv [7] = '{8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] cv [3] = '{8'h00, 8'h21, 8'hF0};
  logic [7:0] fv [3] = '{8'h30, 8'h20, 8'h10};
  logic [7:0] fe [3] = '{8'h01, 8'h00, 8'h00};
  ccd_channel_divider dut (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata,
    .clk_src_sel, .align_req, .dist_clk_in, .osc_clk_in, .ext_clk_in,
    .group2_first_output(g2a), .group2_second_output(g2b), .group2_third_output(g2c),
    .group3_first_output(g3a), .group3_second_output(g3b), .group3_third_output(g3c),
    .group2_pwrdn(p2), .group3_pwrdn(p3), .group2_duty_fix(d2), .group3_duty_fix(d3));
  always #5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////
  task chk(string nm, logic [7:0] got, logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task wr(logic [9:0] a, logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask : wr
  task rd(logic [9:0] a, logic [7:0] e);
    @(negedge ref_clk);
    reg_addr = a;
    @(negedge ref_clk);
    chk("rdata", reg_rdata, e);
  endtask : rd
  task run_len(output int hc, output int lc);
    hc = 0;
    lc = 0;
    while (g3a !== 1'b0) @(negedge ref_clk);
    while (g3a !== 1'b1) @(negedge ref_clk);
    while (g3a === 1'b1) begin
      hc++;
      @(negedge ref_clk);
    end
    while (g3a === 1'b0) begin
      lc++;
      @(negedge ref_clk);
    end
  endtask : run_len
  task end_of_test;
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      end_of_test;
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    foreach (ra[i]) rd(ra[i], rv[i]);
    wr(10'h198, 8'hFF);
    rd(10'h198, 8'h07);
    wr(10'h198, 8'h00);
    foreach (cv[i]) begin
      wr(10'h199, cv[i]);
      run_len(h, l);
      run_len(h, l);
      chk("high", 8'(h), {4'h0, cv[i][3:0]} + 8'h01);
      chk("low", 8'(l), {4'h0, cv[i][7:4]} + 8'h01);
    end
    align_req = 1'b1;
    foreach (fv[i]) begin
      wr(10'h19A, fv[i]);
      repeat (4) @(negedge ref_clk);
      chk("forced", {7'h0, g3a}, fe[i]);
    end
    wr(10'h19A, 8'h40);
    run_len(h, l);
    chk("ignore", 8'(h + l), 8'h11);
    wr(10'h19A, 8'hA0);
    wr(10'h19B, 8'h02);
    for (int p = 0; p < 2; p++) begin
      osc_clk_in = (p == 0);
      ext_clk_in = (p == 1);
      dist_clk_in = (p == 0);
      for (int s = 0; s < 4; s++) begin
        clk_src_sel = 2'(s);
        repeat (4) @(negedge ref_clk);
        chk("route", {7'h0, g3a}, {7'h0, s == 2 ? osc_clk_in : s == 0 ? ext_clk_in :
          dist_clk_in});
      end
    end
    osc_clk_in = 1'b1;
    clk_src_sel = CCD_SRC_OSC;
    wr(10'h19B, 8'h01);
    repeat (4) @(negedge ref_clk);
    chk("divider", {7'h0, g3a}, 8'h00);
    chk("duty", {7'h0, d3}, 8'h00);
    wr(10'h198, 8'h06);
    repeat (4) @(negedge ref_clk);
    chk("pwrdn", {7'h0, g2a}, 8'h00);
    wr(10'h198, 8'h02);
    repeat (4) @(negedge ref_clk);
    chk("direct", {7'h0, g2a}, 8'h01);
    end_of_test;
  end
endmodule : testbench
bind ccd_channel_divider ccd_checker u_chk (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rdata, .group2_first_output, .group2_second_output, .group2_third_output,
  .group3_first_output, .group3_second_output, .group3_third_output, .group2_pwrdn,
  .group3_pwrdn, .group2_duty_fix, .group3_duty_fix);

// >>> verilog/ccd_channel_divider.sv
/*
  Output channel dividers, routing and power-down for output groups two
  and three, with their register file.
  Assumes: every input synchronous to ref_clk; one ref_clk cycle is one
  divider input cycle; the source select and alignment levels come from
  the surrounding device.
*/
`timescale 1ns/1ps
module ccd_channel_divider (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ccd_pkg::CCD_AW-1:0] reg_addr,
  input wire logic [ccd_pkg::CCD_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  output logic [ccd_pkg::CCD_DW-1:0] reg_rdata,
  input wire logic [1:0] clk_src_sel,
  input wire logic align_req,
  input wire logic dist_clk_in,
  input wire logic osc_clk_in,
  input wire logic ext_clk_in,
  output logic group2_first_output,
  output logic group2_second_output,
  output logic group2_third_output,
  output logic group3_first_output,
  output logic group3_second_output,
  output logic group3_third_output,
  output logic group2_pwrdn,
  output logic group3_pwrdn,
  output logic group2_duty_fix,
  output logic group3_duty_fix
);
  import ccd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0] counts_q [CCD_NUM_CH];
  logic [7:0] counts_d [CCD_NUM_CH];
  logic [7:0] ctrl_q [CCD_NUM_CH];
  logic [7:0] ctrl_d [CCD_NUM_CH];
  logic [7:0] route_q [CCD_NUM_CH];
  logic [7:0] route_d [CCD_NUM_CH];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    for (int i = 0; i < CCD_NUM_CH; i++) begin
      counts_d[i] = counts_q[i];
      ctrl_d[i] = ctrl_q[i];
      route_d[i] = route_q[i];
    end
    if (reg_wr) begin
      unique case (reg_addr)
        CCD_OFF_DIV2_COUNTS: counts_d[0] = reg_wdata;
        CCD_OFF_DIV2_CTRL: ctrl_d[0] = reg_wdata;
        CCD_OFF_CH2_ROUTE: route_d[0] = reg_wdata & CCD_RT_USED_MASK;
        CCD_OFF_DIV3_COUNTS: counts_d[1] = reg_wdata;
        CCD_OFF_DIV3_CTRL: ctrl_d[1] = reg_wdata;
        CCD_OFF_CH3_ROUTE: route_d[1] = reg_wdata & CCD_RT_USED_MASK;
        default: ;
      endcase
    end
    unique case (reg_addr)
      CCD_OFF_DIV2_COUNTS: rdata_d = counts_q[0];
      CCD_OFF_DIV2_CTRL: rdata_d = ctrl_q[0];
      CCD_OFF_CH2_ROUTE: rdata_d = route_q[0];
      CCD_OFF_DIV3_COUNTS: rdata_d = counts_q[1];
      CCD_OFF_DIV3_CTRL: rdata_d = ctrl_q[1];
      CCD_OFF_CH3_ROUTE: rdata_d = route_q[1];
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      counts_q[0] <= CCD_RST_DIV2_COUNTS;
      counts_q[1] <= CCD_RST_DIV3_COUNTS;
      for (int i = 0; i < CCD_NUM_CH; i++) begin
        ctrl_q[i] <= CCD_RST_CTRL;
        route_q[i] <= CCD_RST_ROUTE;
      end
      rdata_q <= 8'h00;
    end else begin
      for (int i = 0; i < CCD_NUM_CH; i++) begin
        counts_q[i] <= counts_d[i];
        ctrl_q[i] <= ctrl_d[i];
        route_q[i] <= route_d[i];
      end
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // dividers and output routing

  ccd_state_t st_q [CCD_NUM_CH];
  ccd_state_t st_d [CCD_NUM_CH];
  logic [3:0] cnt_q [CCD_NUM_CH];
  logic [3:0] cnt_d [CCD_NUM_CH];
  logic div_q [CCD_NUM_CH];
  logic div_d [CCD_NUM_CH];
  logic grp_q [CCD_NUM_CH];
  logic grp_d [CCD_NUM_CH];

  always_comb begin
    logic [3:0] lim;
    logic [3:0] phase;
    logic start;
    logic src;
    lim = 4'h0;
    phase = 4'h0;
    start = 1'b0;
    src = 1'b0;
    for (int i = 0; i < CCD_NUM_CH; i++) begin
      st_d[i] = st_q[i];
      cnt_d[i] = cnt_q[i];
      div_d[i] = div_q[i];
      phase = ctrl_q[i][CCD_CTL_PHASE_MSB:CCD_CTL_PHASE_LSB];
      start = ctrl_q[i][CCD_CTL_START_HIGH];
      if (ctrl_q[i][CCD_CTL_BYPASS]) begin
        // divider stopped, input passed through
        st_d[i] = CCD_ST_HOLD;
        cnt_d[i] = 4'h0;
        div_d[i] = dist_clk_in;
      end else if (align_req && !ctrl_q[i][CCD_CTL_IGNORE_ALIGN]) begin
        // static while aligned; force level, ignore set by software
        st_d[i] = CCD_ST_HOLD;
        cnt_d[i] = 4'h0;
        div_d[i] = ctrl_q[i][CCD_CTL_FORCE] ? start : 1'b0;
      end else begin
        unique case (st_q[i])
          CCD_ST_HOLD: begin
            st_d[i] = CCD_ST_DELAY;
            cnt_d[i] = phase;
            div_d[i] = start;
          end
          CCD_ST_DELAY: begin
            div_d[i] = start;
            if (cnt_q[i] == 4'h0) begin
              st_d[i] = CCD_ST_RUN;
            end else begin
              cnt_d[i] = cnt_q[i] - 4'h1;
            end
          end
          CCD_ST_RUN: begin
            lim = div_q[i] ? counts_q[i][CCD_HIGH_MSB:CCD_HIGH_LSB]
                           : counts_q[i][CCD_LOW_MSB:CCD_LOW_LSB];
            if (cnt_q[i] == lim) begin
              cnt_d[i] = 4'h0;
              div_d[i] = !div_q[i];
            end else begin
              cnt_d[i] = cnt_q[i] + 4'h1;
            end
          end
          default: st_d[i] = CCD_ST_HOLD;
        endcase
      end
      // source 10b oscillator, 00b external clock, 01b and 11b no effect
      src = div_q[i];
      if (route_q[i][CCD_RT_DIRECT]) begin
        if (clk_src_sel == CCD_SRC_OSC) begin
          src = osc_clk_in;
        end else if (clk_src_sel == CCD_SRC_EXT) begin
          src = ext_clk_in;
        end else if (clk_src_sel == CCD_SRC_EXT_NODIV) begin
          src = div_q[i];
        end
      end
      grp_d[i] = route_q[i][CCD_RT_PWRDN] ? 1'b0 : src;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < CCD_NUM_CH; i++) begin
        st_q[i] <= CCD_ST_HOLD;
        cnt_q[i] <= 4'h0;
        div_q[i] <= 1'b0;
        grp_q[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < CCD_NUM_CH; i++) begin
        st_q[i] <= st_d[i];
        cnt_q[i] <= cnt_d[i];
        div_q[i] <= div_d[i];
        grp_q[i] <= grp_d[i];
      end
    end
  end

  assign group2_first_output = grp_q[0];
  assign group2_second_output = grp_q[0];
  assign group2_third_output = grp_q[0];
  assign group3_first_output = grp_q[1];
  assign group3_second_output = grp_q[1];
  assign group3_third_output = grp_q[1];
  assign group2_pwrdn = route_q[0][CCD_RT_PWRDN];
  assign group3_pwrdn = route_q[1][CCD_RT_PWRDN];
  assign group2_duty_fix = !route_q[0][CCD_RT_DUTY_FIX_OFF];
  assign group3_duty_fix = !route_q[1][CCD_RT_DUTY_FIX_OFF];
endmodule : ccd_channel_divider

// >>> verilog/ccd_pkg.sv
/*
  Constants for the channel divider block of groups two and three:
  register offsets, field positions, reset values and the divider states.
  Assumes a 10-bit register index as used by the serial control port.
*/
package ccd_pkg;
  localparam int unsigned CCD_NUM_CH = 2;
  localparam int unsigned CCD_AW = 10;
  localparam int unsigned CCD_DW = 8;

  // register offsets
  localparam logic [9:0] CCD_OFF_DIV2_COUNTS = 10'h196;
  localparam logic [9:0] CCD_OFF_DIV2_CTRL = 10'h197;
  localparam logic [9:0] CCD_OFF_CH2_ROUTE = 10'h198;
  localparam logic [9:0] CCD_OFF_DIV3_COUNTS = 10'h199;
  localparam logic [9:0] CCD_OFF_DIV3_CTRL = 10'h19A;
  localparam logic [9:0] CCD_OFF_CH3_ROUTE = 10'h19B;

  // reset values
  localparam logic [7:0] CCD_RST_DIV2_COUNTS = 8'h11;
  localparam logic [7:0] CCD_RST_DIV3_COUNTS = 8'h00;
  localparam logic [7:0] CCD_RST_CTRL = 8'h00;
  localparam logic [7:0] CCD_RST_ROUTE = 8'h00;

  // cycle count fields
  localparam int unsigned CCD_LOW_MSB = 7;
  localparam int unsigned CCD_LOW_LSB = 4;
  localparam int unsigned CCD_HIGH_MSB = 3;
  localparam int unsigned CCD_HIGH_LSB = 0;

  // control fields
  localparam int unsigned CCD_CTL_BYPASS = 7;
  localparam int unsigned CCD_CTL_IGNORE_ALIGN = 6;
  localparam int unsigned CCD_CTL_FORCE = 5;
  localparam int unsigned CCD_CTL_START_HIGH = 4;
  localparam int unsigned CCD_CTL_PHASE_MSB = 3;
  localparam int unsigned CCD_CTL_PHASE_LSB = 0;

  // power and route fields
  localparam int unsigned CCD_RT_PWRDN = 2;
  localparam int unsigned CCD_RT_DIRECT = 1;
  localparam int unsigned CCD_RT_DUTY_FIX_OFF = 0;
  localparam logic [7:0] CCD_RT_USED_MASK = 8'h07;

  // clock source select codes
  localparam logic [1:0] CCD_SRC_EXT = 2'h0;
  localparam logic [1:0] CCD_SRC_EXT_NODIV = 2'h1;
  localparam logic [1:0] CCD_SRC_OSC = 2'h2;

  typedef enum logic [1:0] {
    CCD_ST_HOLD,
    CCD_ST_DELAY,
    CCD_ST_RUN
  } ccd_state_t;
endpackage : ccd_pkg
